// file: design/dap_defs.svh
`ifndef DAP_DEFS_SVH
`define DAP_DEFS_SVH
// config space offsets
`define DAP_OFS_IRQ0_ROUTE 8'h60
`define DAP_OFS_IRQ1_ROUTE 8'h61
`define DAP_OFS_DMA_ROUTE 8'h62
// reset values: routes disabled
`define DAP_RST_IRQ_ROUTE 8'h00
`define DAP_RST_DMA_ROUTE 8'h00
// field positions
`define DAP_IRQ_LVL_LSB 0
`define DAP_IRQ_LVL_MSB 3
`define DAP_DMA0_CH_LSB 0
`define DAP_DMA0_CH_MSB 2
`define DAP_DMA0_EN_BIT 3
`define DAP_DMA1_CH_LSB 4
`define DAP_DMA1_CH_MSB 6
`define DAP_DMA1_EN_BIT 7
// channel that does not exist on the request pins
`define DAP_CASCADE_CH 3'h4
// legal board interrupt levels (bit n = level n allowed)
`define DAP_IRQ_LEGAL_MAP 16'hdef8
`endif

// file: design/dap_pin_mux.sv
`timescale 1ns/1ps
`include "dap_defs.svh"
module dap_pin_mux (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic kbc_enable,
  input wire dap_pkg::dap_kbc_s kbc,
  output logic kbc_data_in,
  input wire logic tc_event,
  input wire logic [2:0] active_chan,
  input wire logic [7:0] autoinit_en,
  input wire logic [7:0] mask_clr,
  input wire logic status_clr,
  output logic [7:0] chan_mask,
  output logic [7:0] count_exhausted_flag,
  output logic count_done_pulse,
  output logic reload_pulse,
  output logic service_end,
  input wire dap_pkg::dap_grant_s grant,
  input wire logic [7:0] channel_request_inputs,
  output logic [7:0] dma_req_to_core,
  input wire logic [1:0] board_dma_requests,
  output logic [1:0] board_dma_grants_n,
  output logic [2:0] encoded_grant_bits,
  input wire logic keyboard_data_line_in,
  output logic keyboard_data_line_out,
  output logic keyboard_data_line_oe,
  output logic keyboard_clock_line,
  output logic addr_bit20_gate_n,
  output logic keyboard_host_reset_n,
  input wire logic [15:0] legacy_irq_inputs,
  input wire logic [1:0] board_irq_inputs,
  output logic [15:0] irq_to_pic
);

  // ****************************************
  // decoding helpers
  // ****************************************
  // one-hot of a channel number, used for grants and routing
  function automatic logic [7:0] chan_hot(input logic [2:0] ch);
    chan_hot = 8'h01 << ch;
  endfunction

  // one-hot of a board interrupt level; illegal levels route nowhere
  function automatic logic [15:0] irq_hot(input logic [7:0] route);
    logic [3:0] lvl;
    lvl = route[`DAP_IRQ_LVL_MSB:`DAP_IRQ_LVL_LSB];
    irq_hot = (16'h0001 << lvl) & `DAP_IRQ_LEGAL_MAP;
  endfunction

  dap_pkg::dap_state_s st_reg;
  dap_pkg::dap_state_s st_next;
  logic [7:0] grant_hot;
  logic [7:0] tc_hot;
  logic [2:0] bch0;
  logic [2:0] bch1;
  logic [7:0] board_hot;

  assign grant_hot = grant.valid ? chan_hot(grant.chan) : 8'h00;
  assign tc_hot = tc_event ? chan_hot(active_chan) : 8'h00;
  assign bch0 = st_reg.dma_route[`DAP_DMA0_CH_MSB:`DAP_DMA0_CH_LSB];
  assign bch1 = st_reg.dma_route[`DAP_DMA1_CH_MSB:`DAP_DMA1_CH_LSB];
  // routed board requests as channel bits
  assign board_hot =
    ((st_reg.dma_route[`DAP_DMA0_EN_BIT] && st_reg.breq_s2[0]) ? chan_hot(bch0) : 8'h00) |
    ((st_reg.dma_route[`DAP_DMA1_EN_BIT] && st_reg.breq_s2[1]) ? chan_hot(bch1) : 8'h00);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    st_next = st_reg;
    // config writes; only the three route registers exist here
    if (cfg_wr) begin
      unique case (cfg_addr)
        `DAP_OFS_IRQ0_ROUTE: st_next.irq0_route = cfg_wdata;
        `DAP_OFS_IRQ1_ROUTE: st_next.irq1_route = cfg_wdata;
        `DAP_OFS_DMA_ROUTE: st_next.dma_route = cfg_wdata;
        default: ;
      endcase
    end
    unique case (cfg_addr)
      `DAP_OFS_IRQ0_ROUTE: st_next.cfg_rdata = st_reg.irq0_route;
      `DAP_OFS_IRQ1_ROUTE: st_next.cfg_rdata = st_reg.irq1_route;
      `DAP_OFS_DMA_ROUTE: st_next.cfg_rdata = st_reg.dma_route;
      default: st_next.cfg_rdata = 8'h00;
    endcase
    // pins are asynchronous: two flops before anything reads them
    st_next.req_s1 = channel_request_inputs;
    st_next.req_s2 = st_reg.req_s1;
    st_next.breq_s1 = board_dma_requests;
    st_next.breq_s2 = st_reg.breq_s1;
    st_next.irq_s1 = legacy_irq_inputs;
    st_next.irq_s2 = st_reg.irq_s1;
    st_next.birq_s1 = board_irq_inputs;
    st_next.birq_s2 = st_reg.birq_s1;
    st_next.kbd_s1 = keyboard_data_line_in;
    st_next.kbd_s2 = st_reg.kbd_s1;
    // request 4 is cascade and has no pin
    st_next.dreq = ((st_reg.req_s2 & ~chan_hot(`DAP_CASCADE_CH)) | board_hot);
    st_next.irq_out = st_reg.irq_s2
      | (st_reg.birq_s2[0] ? irq_hot(st_reg.irq0_route) : 16'h0000)
      | (st_reg.birq_s2[1] ? irq_hot(st_reg.irq1_route) : 16'h0000);
    // terminal count: pulse, end service, reload, flag updates
    st_next.done_pulse = tc_event;
    st_next.svc_end = tc_event;
    st_next.reload = tc_event && autoinit_en[active_chan];
    // a set in the same cycle as a clear wins
    st_next.tc_flag = (status_clr ? 8'h00 : st_reg.tc_flag) | tc_hot;
    st_next.mask = (st_reg.mask & ~mask_clr) | (tc_hot & ~autoinit_en);
    // shared grant pins follow the keyboard controller enable
    if (kbc_enable) begin
      st_next.ack_pins = grant.valid ? grant.chan : 3'h0;
      st_next.kb_pins = {~kbc.rst_out, ~kbc.a20_out, kbc.clk_out, kbc.data_out};
      st_next.kb_data_oe = kbc.data_oe;
    end else begin
      st_next.ack_pins = ~grant_hot[2:0];
      st_next.kb_pins = ~{grant_hot[7], grant_hot[6], grant_hot[5], grant_hot[3]};
      st_next.kb_data_oe = 1'b1;
    end
    st_next.bgrant_n = ~{grant.valid && st_reg.dma_route[`DAP_DMA1_EN_BIT] && grant.chan == bch1,
      grant.valid && st_reg.dma_route[`DAP_DMA0_EN_BIT] && grant.chan == bch0};
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.irq0_route <= `DAP_RST_IRQ_ROUTE;
      st_reg.irq1_route <= `DAP_RST_IRQ_ROUTE;
      st_reg.dma_route <= `DAP_RST_DMA_ROUTE;
      // grant pins idle high; keyboard pins idle inactive
      st_reg.ack_pins <= 3'h7;
      st_reg.kb_pins <= 4'hf;
      st_reg.bgrant_n <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs, all from flops
  // ****************************************
  assign cfg_rdata = st_reg.cfg_rdata;
  assign kbc_data_in = st_reg.kbd_s2;
  assign chan_mask = st_reg.mask;
  assign count_exhausted_flag = st_reg.tc_flag;
  assign count_done_pulse = st_reg.done_pulse;
  assign reload_pulse = st_reg.reload;
  assign service_end = st_reg.svc_end;
  assign dma_req_to_core = st_reg.dreq;
  assign board_dma_grants_n = st_reg.bgrant_n;
  assign encoded_grant_bits = st_reg.ack_pins;
  assign keyboard_data_line_out = st_reg.kb_pins[0];
  assign keyboard_data_line_oe = st_reg.kb_data_oe;
  assign keyboard_clock_line = st_reg.kb_pins[1];
  assign addr_bit20_gate_n = st_reg.kb_pins[2];
  assign keyboard_host_reset_n = st_reg.kb_pins[3];
  assign irq_to_pic = st_reg.irq_out;

  // ****************************************
  // assertions
  // ****************************************
  a_done_pulse_follows: assert property (@(posedge clk) disable iff (!nrst)
    tc_event |=> count_done_pulse) else $error("count done pulse missing after tc");
  a_reload_on_autoinit: assert property (@(posedge clk) disable iff (!nrst)
    (tc_event && autoinit_en[active_chan]) |=> (reload_pulse && service_end))
    else $error("reload or service end missing");
  a_tc_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    tc_event |=> count_exhausted_flag[$past(active_chan)]) else $error("tc flag not set");
  a_mask_autoinit: assert property (@(posedge clk) disable iff (!nrst)
    (tc_event && !autoinit_en[active_chan] && !mask_clr[active_chan])
    |=> chan_mask[$past(active_chan)]) else $error("mask not set on terminal count");
  a_no_cascade_req: assert property (@(posedge clk) disable iff (!nrst)
    (!st_reg.dma_route[`DAP_DMA0_EN_BIT] && !st_reg.dma_route[`DAP_DMA1_EN_BIT])
    |=> !dma_req_to_core[4]) else $error("request on cascade channel");
  a_encoded_code: assert property (@(posedge clk) disable iff (!nrst)
    (kbc_enable && grant.valid) |=> encoded_grant_bits == $past(grant.chan))
    else $error("encoded grant code wrong");
  a_direct_grant2: assert property (@(posedge clk) disable iff (!nrst)
    (!kbc_enable && grant.valid && grant.chan == 3'h2) |=> !encoded_grant_bits[2])
    else $error("channel 2 grant not asserted");
  a_kb_grant7: assert property (@(posedge clk) disable iff (!nrst)
    (!kbc_enable && grant.valid && grant.chan == 3'h7) |=> !keyboard_host_reset_n)
    else $error("channel 7 grant missing on shared pin");
  a_legacy_irq_sync: assert property (@(posedge clk) disable iff (!nrst)
    legacy_irq_inputs[1] [*3] |=> irq_to_pic[1]) else $error("legacy irq not passed");
endmodule

// file: design/dap_pkg.sv
package dap_pkg;
  // all state of the pin mux, registered in one place
  typedef struct packed {
    logic [7:0] irq0_route;
    logic [7:0] irq1_route;
    logic [7:0] dma_route;
    logic [7:0] req_s1;
    logic [7:0] req_s2;
    logic [1:0] breq_s1;
    logic [1:0] breq_s2;
    logic [15:0] irq_s1;
    logic [15:0] irq_s2;
    logic [1:0] birq_s1;
    logic [1:0] birq_s2;
    logic kbd_s1;
    logic kbd_s2;
    logic [7:0] mask;
    logic [7:0] tc_flag;
    logic done_pulse;
    logic reload;
    logic svc_end;
    logic [2:0] ack_pins;
    logic [3:0] kb_pins;
    logic kb_data_oe;
    logic [1:0] bgrant_n;
    logic [7:0] dreq;
    logic [15:0] irq_out;
    logic [7:0] cfg_rdata;
  } dap_state_s;
  // grant from the dma core
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
  } dap_grant_s;
  // keyboard controller side of the shared pins
  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic clk_out;
    logic a20_out;
    logic rst_out;
  } dap_kbc_s;
endpackage

// file: tb/dap_isa_side.sv
`timescale 1ns/1ps
// ********************
// far side: requesters and grant decoder
// ********************
module dap_isa_side (
  input wire logic kbc_enable,
  input wire logic [2:0] encoded_grant_bits,
  input wire logic [7:0] want,
  output logic [7:0] channel_request_inputs,
  output logic [7:0] dack_n
);
  // each peripheral raises its own line; no peripheral sits on the cascade channel
  assign channel_request_inputs = want & 8'hef;
  // outside three-to-eight decode, only meaningful while codes are sent
  assign dack_n = kbc_enable ? ~(8'h01 << encoded_grant_bits) : 8'hff;
endmodule

// file: tb/dap_pin_mux_bench.sv
`timescale 1ns/1ps
module dap_pin_mux_bench;
  // ********************
  // signals
  // ********************
  logic clk = 0, nrst = 0, cfg_wr = 0, kbc_enable = 1, tc_event = 0, status_clr = 0;
  logic [7:0] cfg_addr = 0, cfg_wdata = 0, cfg_rdata, autoinit_en = 0, want = 0, mclr = 0;
  logic kb_in = 1;
  logic [7:0] dreq, mask, flag, dack_n, req_pins;
  logic [2:0] active_chan = 0, egb, e3;
  logic [3:0] e4;
  logic [1:0] bdrq = 0, birq = 0, bgnt_n;
  logic [15:0] lirq = 0, irq;
  logic done, reload, svc_end, kd_in, kd_out, kd_oe, kclk, a20_n, krst_n, kbc_din;
  dap_pkg::dap_kbc_s kbc = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  dap_pkg::dap_grant_s grant = '0;
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  int chs[7] = '{0, 1, 2, 3, 5, 6, 7};
  // released data wire sits at its pull-up unless the keyboard pulls it low
  assign kd_in = kd_oe ? kd_out : kb_in;
  always #2.5 clk = ~clk;
  dap_pin_mux dap_pin_mux_i (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .kbc_enable(kbc_enable), .kbc(kbc),
    .kbc_data_in(kbc_din), .tc_event(tc_event), .active_chan(active_chan),
    .autoinit_en(autoinit_en), .mask_clr(mclr), .status_clr(status_clr), .chan_mask(mask),
    .count_exhausted_flag(flag), .count_done_pulse(done), .reload_pulse(reload),
    .service_end(svc_end), .grant(grant), .channel_request_inputs(req_pins),
    .dma_req_to_core(dreq), .board_dma_requests(bdrq), .board_dma_grants_n(bgnt_n),
    .encoded_grant_bits(egb), .keyboard_data_line_in(kd_in), .keyboard_data_line_out(kd_out),
    .keyboard_data_line_oe(kd_oe), .keyboard_clock_line(kclk), .addr_bit20_gate_n(a20_n),
    .keyboard_host_reset_n(krst_n), .legacy_irq_inputs(lirq), .board_irq_inputs(birq),
    .irq_to_pic(irq));
  dap_isa_side dap_isa_side_i (.kbc_enable(kbc_enable), .encoded_grant_bits(egb),
    .want(want), .channel_request_inputs(req_pins), .dack_n(dack_n));
  // ********************
  // tasks
  // ********************
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 0;
  endtask
  // read data is registered, so allow two edges after the address moves
  task cfg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    cfg_addr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("cfg_rdata", exp, cfg_rdata);
  endtask
  task tc(input logic [2:0] c, input logic [7:0] ai);
    @(posedge clk);
    tc_event <= 1;
    active_chan <= c;
    autoinit_en <= ai;
    @(posedge clk);
    tc_event <= 0;
    @(negedge clk);
  endtask
  task give(input logic [2:0] c);
    @(posedge clk);
    grant <= '{1'b1, c};
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task wrap_up;
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the roughly 80 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ********************
  // sequence
  // ********************
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    chk("idle_code", 3'h7, egb);
    cfg_read(8'h62, 8'h00);
    cfg_write(8'h60, 8'h07);
    cfg_write(8'h61, 8'h0e);
    cfg_write(8'h62, 8'h0b);
    cfg_write(8'h63, 8'h55);
    cfg_read(8'h60, 8'h07);
    cfg_read(8'h61, 8'h0e);
    cfg_read(8'h62, 8'h0b);
    cfg_read(8'h63, 8'h00);
    tc(3'h2, 8'h00);
    chk("tc_pulse", 3'b101, {svc_end, reload, done});
    chk("tc_mask_flag", 16'h0404, {mask, flag});
    tc(3'h1, 8'h02);
    chk("tc_reload", 3'b111, {svc_end, reload, done});
    chk("tc_auto_mask", 16'h0406, {mask, flag});
    @(negedge clk);
    chk("tc_pulse_end", 1'b0, done);
    @(posedge clk);
    status_clr <= 1;
    mclr <= 8'h04;
    @(posedge clk);
    status_clr <= 0;
    mclr <= 8'h00;
    @(negedge clk);
    chk("tc_flag_clr", 16'h0000, {mask, flag});
    // a terminal count in the same cycle as both clears must still land
    @(posedge clk);
    tc_event <= 1;
    active_chan <= 3'h0;
    status_clr <= 1;
    mclr <= 8'h01;
    @(posedge clk);
    tc_event <= 0;
    status_clr <= 0;
    mclr <= 8'h00;
    @(negedge clk);
    chk("tc_set_wins", 16'h0101, {mask, flag});
    give(3'h6);
    chk("code", 3'h6, egb);
    chk("decoded", 8'hbf, dack_n);
    chk("kbd_pass", 5'b11110, {krst_n, a20_n, kclk, kd_out, kd_oe});
    // keyboard pulls the released data wire low: two sync flops, then seen
    @(posedge clk);
    kb_in <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("kbd_data_in", 1'b0, kbc_din);
    @(posedge clk);
    kbc_enable <= 0;
    foreach (chs[i]) begin
      give(chs[i][2:0]);
      e3 = ~(3'b001 << chs[i]);
      e4 = ~{chs[i] == 7, chs[i] == 6, chs[i] == 5, chs[i] == 3};
      chk("direct_grant", e3, egb);
      chk("kbd_grant", {e4, 1'b1}, {krst_n, a20_n, kclk, kd_out, kd_oe});
      chk("board_grant", (chs[i] == 3) ? 2'b10 : 2'b11, bgnt_n);
    end
    @(posedge clk);
    want <= 8'h12;
    bdrq <= 2'b01;
    lirq <= 16'h0020;
    birq <= 2'b11;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("requests", 8'h0a, dreq);
    chk("irqs", 16'h40a0, irq);
    wrap_up();
  end
endmodule
